// File: adc_config_status_regs.vh
// Behaviour
// - writing bit 7 starts soft reset, self-clears
// - bit 0 mirrors soft reset, also starts it
// - bit 4 enables serial output (serial_out_enable)
// - bit 3 reads back serial output enable
// - bit 2 reads back address direction bit
// - configuration register resets to 0x18
`ifndef ADC_CONFIG_STATUS_REGS_VH
`define ADC_CONFIG_STATUS_REGS_VH
`define ADDR_IF_SETUP 7'h00
`define ADDR_CH2_OFS_MID 7'h37
`define ADDR_CH2_OFS_TOP 7'h38
`define ADDR_CH3_GAIN_LO 7'h39
`define ADDR_CHAN3_GAIN_MIDDLE_BYTE 7'h3A
`define ADDR_CH3_GAIN_TOP 7'h3B
`define ADDR_CH3_OFS_LO 7'h3C
`define ADDR_CH3_OFS_MID 7'h3D
`define ADDR_CH3_OFS_TOP 7'h3E
`define ADDR_MCLK_TALLY 7'h3F
`define ADDR_OVF_FLAGS 7'h40
`define ADDR_SETTLED_FLAGS 7'h41
`define ADDR_INT_FAULT 7'h42
`define ADDR_SPI_FAULT 7'h47
`define ADDR_OVERRANGE 7'h48
`define BIT_SOFT_RESET 7
`define BIT_ADDR_ASCEND 5
`define BIT_OUT_ENABLE 4
`define BIT_OUT_ENABLE_COPY 3
`define BIT_ASCEND_COPY 2
`define BIT_SOFT_RESET_COPY 0
`define IF_SETUP_RESET 8'h18
`define GAIN_TOP_MASK 8'h1F
`define FLAG_MASK 8'h0F
`define SOFT_RESET_CYCLES 4'h4
`endif

// File: adc_config_status_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_config_status_regs.vh"
module adc_config_status_regs #(
	parameter RST_CYCLES = `SOFT_RESET_CYCLES
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// register access
	input wire wr_en,
	input wire rd_en,
	input wire [6:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata,
	output reg rvalid,
	// streaming address step
	input wire step_req,
	output reg [6:0] next_stream_addr,
	// serial output control and soft reset status
	output reg serial_out_enable,
	output reg address_ascend,
	output reg soft_reset_busy,
	// status inputs
	input wire mclk_tick,
	input wire [3:0] ovf_in,
	input wire [3:0] settled_in,
	input wire [3:0] int_fault_in,
	input wire [3:0] spi_fault_in,
	input wire [3:0] overrange_in,
	// calibration outputs
	output reg [7:0] ch2_ofs_mid,
	output reg [7:0] ch2_ofs_top,
	output reg [7:0] ch3_gain_lo,
	output reg [7:0] chan3_gain_middle_byte,
	output reg [7:0] ch3_gain_top,
	output reg [7:0] ch3_ofs_lo,
	output reg [7:0] ch3_ofs_mid,
	output reg [7:0] ch3_ofs_top
);
	reg [3:0] rst_cnt;
	reg [7:0] mclk_tally;
	reg [3:0] ovf_flags;
	reg [3:0] settled_flags;
	reg [3:0] int_fault;
	reg [3:0] spi_fault;
	reg [3:0] overrange;
	reg [7:0] next_rdata;
	wire setup_wr;
	wire start_soft;
	wire [3:0] acc_slot;
	reg [1:0] sr_state;

	localparam [7:0] SETUP_RST = `IF_SETUP_RESET;
	localparam [1:0] SR_IDLE = 2'b01;
	localparam [1:0] SR_RUN = 2'b10;

	// register slots picked by the address decoder
	localparam [3:0] SLOT_SETUP = 4'h0;
	localparam [3:0] SLOT_C2_OFS_MID = 4'h1;
	localparam [3:0] SLOT_C2_OFS_TOP = 4'h2;
	localparam [3:0] SLOT_C3_GAIN_LO = 4'h3;
	localparam [3:0] SLOT_C3_GAIN_MID = 4'h4;
	localparam [3:0] SLOT_C3_GAIN_TOP = 4'h5;
	localparam [3:0] SLOT_C3_OFS_LO = 4'h6;
	localparam [3:0] SLOT_C3_OFS_MID = 4'h7;
	localparam [3:0] SLOT_C3_OFS_TOP = 4'h8;
	localparam [3:0] SLOT_TALLY = 4'h9;
	localparam [3:0] SLOT_OVF = 4'hA;
	localparam [3:0] SLOT_SETTLED = 4'hB;
	localparam [3:0] SLOT_INT_FAULT = 4'hC;
	localparam [3:0] SLOT_SPI_FAULT = 4'hD;
	localparam [3:0] SLOT_OVERRANGE = 4'hE;
	localparam [3:0] SLOT_NONE = 4'hF;

	// address decode shared by write and read paths
	function [3:0] reg_slot;
		input [6:0] a;
		begin
			if (a == `ADDR_IF_SETUP)
				reg_slot = SLOT_SETUP;
			else if (a == `ADDR_CH2_OFS_MID)
				reg_slot = SLOT_C2_OFS_MID;
			else if (a == `ADDR_CH2_OFS_TOP)
				reg_slot = SLOT_C2_OFS_TOP;
			else if (a == `ADDR_CH3_GAIN_LO)
				reg_slot = SLOT_C3_GAIN_LO;
			else if (a == `ADDR_CHAN3_GAIN_MIDDLE_BYTE)
				reg_slot = SLOT_C3_GAIN_MID;
			else if (a == `ADDR_CH3_GAIN_TOP)
				reg_slot = SLOT_C3_GAIN_TOP;
			else if (a == `ADDR_CH3_OFS_LO)
				reg_slot = SLOT_C3_OFS_LO;
			else if (a == `ADDR_CH3_OFS_MID)
				reg_slot = SLOT_C3_OFS_MID;
			else if (a == `ADDR_CH3_OFS_TOP)
				reg_slot = SLOT_C3_OFS_TOP;
			else if (a == `ADDR_MCLK_TALLY)
				reg_slot = SLOT_TALLY;
			else if (a == `ADDR_OVF_FLAGS)
				reg_slot = SLOT_OVF;
			else if (a == `ADDR_SETTLED_FLAGS)
				reg_slot = SLOT_SETTLED;
			else if (a == `ADDR_INT_FAULT)
				reg_slot = SLOT_INT_FAULT;
			else if (a == `ADDR_SPI_FAULT)
				reg_slot = SLOT_SPI_FAULT;
			else if (a == `ADDR_OVERRANGE)
				reg_slot = SLOT_OVERRANGE;
			else
				reg_slot = SLOT_NONE;
		end
	endfunction

	// read-only flag nibble, reserved bits zero
	function [7:0] flag_byte;
		input [3:0] f;
		begin
			flag_byte = {4'h0, f};
		end
	endfunction

	assign acc_slot = reg_slot(addr);
	assign setup_wr = wr_en && (acc_slot == SLOT_SETUP);
	assign start_soft = setup_wr && !soft_reset_busy &&
		(wdata[`BIT_SOFT_RESET] || wdata[`BIT_SOFT_RESET_COPY]);

	// soft reset sequencer
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sr_state <= SR_IDLE;
			soft_reset_busy <= 1'b0;
			rst_cnt <= 4'h0;
		end else begin
			case (sr_state)
				SR_IDLE: begin
					if (start_soft) begin
						sr_state <= SR_RUN;
						soft_reset_busy <= 1'b1;
						rst_cnt <= RST_CYCLES[3:0];
					end
				end
				SR_RUN: begin
					rst_cnt <= rst_cnt - 4'h1;
					if (rst_cnt <= 4'h1) begin
						sr_state <= SR_IDLE;
						soft_reset_busy <= 1'b0;
					end
				end
				default: begin
					sr_state <= SR_IDLE;
					soft_reset_busy <= 1'b0;
				end
			endcase
		end
	end

	// configuration bits
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			serial_out_enable <= SETUP_RST[`BIT_OUT_ENABLE];
			address_ascend <= SETUP_RST[`BIT_ADDR_ASCEND];
		end else if (soft_reset_busy) begin
			serial_out_enable <= SETUP_RST[`BIT_OUT_ENABLE];
			address_ascend <= SETUP_RST[`BIT_ADDR_ASCEND];
		end else if (setup_wr && !start_soft) begin
			address_ascend <= wdata[`BIT_ADDR_ASCEND];
			serial_out_enable <= wdata[`BIT_OUT_ENABLE];
		end
	end

	// calibration bytes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ch2_ofs_mid <= 8'h00;
			ch2_ofs_top <= 8'h00;
			ch3_gain_lo <= 8'h00;
			chan3_gain_middle_byte <= 8'h00;
			ch3_gain_top <= 8'h00;
			ch3_ofs_lo <= 8'h00;
			ch3_ofs_mid <= 8'h00;
			ch3_ofs_top <= 8'h00;
		end else if (soft_reset_busy) begin
			ch2_ofs_mid <= 8'h00;
			ch2_ofs_top <= 8'h00;
			ch3_gain_lo <= 8'h00;
			chan3_gain_middle_byte <= 8'h00;
			ch3_gain_top <= 8'h00;
			ch3_ofs_lo <= 8'h00;
			ch3_ofs_mid <= 8'h00;
			ch3_ofs_top <= 8'h00;
		end else if (wr_en) begin
			if (acc_slot == SLOT_C2_OFS_MID)
				ch2_ofs_mid <= wdata;
			else if (acc_slot == SLOT_C2_OFS_TOP)
				ch2_ofs_top <= wdata;
			else if (acc_slot == SLOT_C3_GAIN_LO)
				ch3_gain_lo <= wdata;
			else if (acc_slot == SLOT_C3_GAIN_MID)
				chan3_gain_middle_byte <= wdata;
			else if (acc_slot == SLOT_C3_GAIN_TOP)
				ch3_gain_top <= wdata & `GAIN_TOP_MASK;
			else if (acc_slot == SLOT_C3_OFS_LO)
				ch3_ofs_lo <= wdata;
			else if (acc_slot == SLOT_C3_OFS_MID)
				ch3_ofs_mid <= wdata;
			else if (acc_slot == SLOT_C3_OFS_TOP)
				ch3_ofs_top <= wdata;
		end
	end

	// status capture, sticky flags except settled flags (follow settled_in), no bus write path
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mclk_tally <= 8'h00;
			ovf_flags <= 4'h0;
			settled_flags <= 4'h0;
			int_fault <= 4'h0;
			spi_fault <= 4'h0;
			overrange <= 4'h0;
		end else if (soft_reset_busy) begin
			mclk_tally <= 8'h00;
			ovf_flags <= 4'h0;
			settled_flags <= 4'h0;
			int_fault <= 4'h0;
			spi_fault <= 4'h0;
			overrange <= 4'h0;
		end else begin
			if (mclk_tick)
				mclk_tally <= mclk_tally + 8'h01;
			ovf_flags <= ovf_flags | ovf_in;
			settled_flags <= settled_in;
			int_fault <= int_fault | int_fault_in;
			spi_fault <= spi_fault | spi_fault_in;
			overrange <= overrange | overrange_in;
		end
	end

	// read mux
	always @* begin
		next_rdata = 8'h00;
		if (acc_slot == SLOT_SETUP) begin
			next_rdata[`BIT_ADDR_ASCEND] = address_ascend;
			next_rdata[`BIT_OUT_ENABLE] = serial_out_enable;
			next_rdata[`BIT_OUT_ENABLE_COPY] = serial_out_enable;
			next_rdata[`BIT_ASCEND_COPY] = address_ascend;
			next_rdata[`BIT_SOFT_RESET] = soft_reset_busy;
			next_rdata[`BIT_SOFT_RESET_COPY] = soft_reset_busy;
		end else if (acc_slot == SLOT_C2_OFS_MID)
			next_rdata = ch2_ofs_mid;
		else if (acc_slot == SLOT_C2_OFS_TOP)
			next_rdata = ch2_ofs_top;
		else if (acc_slot == SLOT_C3_GAIN_LO)
			next_rdata = ch3_gain_lo;
		else if (acc_slot == SLOT_C3_GAIN_MID)
			next_rdata = chan3_gain_middle_byte;
		else if (acc_slot == SLOT_C3_GAIN_TOP)
			next_rdata = ch3_gain_top;
		else if (acc_slot == SLOT_C3_OFS_LO)
			next_rdata = ch3_ofs_lo;
		else if (acc_slot == SLOT_C3_OFS_MID)
			next_rdata = ch3_ofs_mid;
		else if (acc_slot == SLOT_C3_OFS_TOP)
			next_rdata = ch3_ofs_top;
		else if (acc_slot == SLOT_TALLY)
			next_rdata = mclk_tally;
		else if (acc_slot == SLOT_OVF)
			next_rdata = flag_byte(ovf_flags);
		else if (acc_slot == SLOT_SETTLED)
			next_rdata = flag_byte(settled_flags);
		else if (acc_slot == SLOT_INT_FAULT)
			next_rdata = flag_byte(int_fault);
		else if (acc_slot == SLOT_SPI_FAULT)
			next_rdata = flag_byte(spi_fault);
		else if (acc_slot == SLOT_OVERRANGE)
			next_rdata = flag_byte(overrange);
	end

	// read data and stream address
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
			next_stream_addr <= 7'h00;
		end else begin
			rvalid <= rd_en;
			if (rd_en)
				rdata <= next_rdata;
			if (step_req)
				next_stream_addr <= address_ascend ?
					addr + 7'h01 : addr - 7'h01;
		end
	end
endmodule // adc_config_status_regs
`default_nettype wire

// File: regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module regs_chk (
	input wire clk, rst_b, wr_en, rd_en, step_req, rvalid,
	input wire serial_out_enable, address_ascend, soft_reset_busy,
	input wire [6:0] addr, next_stream_addr,
	input wire [7:0] wdata, rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire w0 = wr_en && addr == 7'h00 && !soft_reset_busy;
	rv_a: assert property (rvalid == $past(rd_en)) else $error("rvalid");
	srst_go_a: assert property (w0 && wdata[7] |=> soft_reset_busy)
		else $error("soft reset");
	mir_go_a: assert property (w0 && wdata[0] |=> soft_reset_busy)
		else $error("mirror reset");
	cfg_wr_a: assert property (w0 && !wdata[7] && !wdata[0] |=>
		serial_out_enable == $past(wdata[4])
		&& address_ascend == $past(wdata[5])) else $error("cfg");
	busy_len_a: assert property ($rose(soft_reset_busy) |->
		soft_reset_busy[*4] ##1 !soft_reset_busy) else $error("busy");
	busy_val_a: assert property ($past(soft_reset_busy) |->
		serial_out_enable && !address_ascend) else $error("reset val");
	step_a: assert property (step_req && address_ascend |=>
		next_stream_addr == $past(addr) + 7'h01) else $error("step");
	step_dn_a: assert property (step_req && !address_ascend |=>
		next_stream_addr == $past(addr) - 7'h01) else $error("step down");
	mirror_a: assert property (rd_en && addr == 7'h00 && !wr_en |=>
		rdata[3:2] == {$past(serial_out_enable), $past(address_ascend)}
		&& !rdata[6] && !rdata[1]) else $error("mirror");
	cover property (w0 && wdata[7]);
	cover property (w0 && wdata[0]);
	cover property (step_req && !address_ascend);
endmodule // regs_chk
bind adc_config_status_regs regs_chk chk_i (.*);
`default_nettype wire

// File: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire clk,
	output logic wr_en, rd_en,
	output logic [6:0] addr,
	output logic [7:0] wdata,
	input wire [7:0] rdata
);
	initial {wr_en, rd_en, addr, wdata} = 0;
	task wr(input [6:0] a, input [7:0] v);
		@(posedge clk) #1 {wr_en, addr, wdata} = {1'b1, a, v};
		@(posedge clk) #1 {wr_en, wdata} = {1'b0, ~v};
	endtask
	task rd(input [6:0] a, output [7:0] v);
		@(posedge clk) #1 {rd_en, addr} = {1'b1, a};
		@(posedge clk) #1 rd_en = 0;
		v = rdata;
	endtask
endmodule // host_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, rst_b = 0, step_req = 0, mclk_tick = 0;
	logic [3:0] ovf_in = 0, settled_in = 0;
	logic [3:0] int_fault_in = 0, spi_fault_in = 0, overrange_in = 0;
	wire wr_en, rd_en, rvalid, serial_out_enable, address_ascend;
	wire soft_reset_busy;
	wire [6:0] addr, next_stream_addr;
	wire [7:0] wdata, rdata, ch2_ofs_mid, ch2_ofs_top, ch3_gain_lo;
	wire [7:0] chan3_gain_middle_byte, ch3_gain_top, ch3_ofs_lo, ch3_ofs_mid;
	wire [7:0] ch3_ofs_top;
	int n_errors = 0, checks_done = 0, cyc = 0;
	logic [7:0] d;
	always #2 clk = ~clk;
	host_model host (.*);
	adc_config_status_regs dut (.*);
	task chk(input [7:0] g, e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task rc(input [6:0] a, input [7:0] e);
		host.rd(a, d);
		chk(d, e);
		chk({7'h00, rvalid}, 8'h01);
	endtask
	task t_cal;
		host.wr(7'h3B, 8'hFF);
		rc(7'h3B, 8'h1F);
		chk(ch3_gain_top, 8'h1F);
		host.wr(7'h37, 8'hA5);
		chk(ch2_ofs_mid, 8'hA5);
		rc(7'h37, 8'hA5);
	endtask
	task t_cfg;
		rc(7'h00, 8'h18);
		host.wr(7'h00, 8'h20);
		step_req = 1;
		rc(7'h00, 8'h24);
		step_req = 0;
		chk({1'b0, next_stream_addr}, 8'h01);
		host.wr(7'h00, 8'h00);
		step_req = 1;
		rc(7'h00, 8'h00);
		step_req = 0;
		chk({1'b0, next_stream_addr}, 8'h7F);
		chk({7'h00, serial_out_enable}, 8'h00);
	endtask
	task t_srst(input [7:0] v);
		host.wr(7'h39, 8'h5A);
		rc(7'h39, 8'h5A);
		host.wr(7'h00, v | 8'h20);
		rc(7'h00, 8'h99);
		repeat (6) @(posedge clk);
		rc(7'h00, 8'h18);
		rc(7'h39, 8'h00);
	endtask
	task t_ro;
		{ovf_in, settled_in, mclk_tick} = {4'h5, 4'hA, 1'b1};
		{int_fault_in, spi_fault_in, overrange_in} = 12'h9C3;
		repeat (3) @(posedge clk);
		#1 {ovf_in, mclk_tick} = 0;
		{int_fault_in, spi_fault_in, overrange_in} = 12'h000;
		host.wr(7'h3F, 8'hFF);
		host.wr(7'h40, 8'hFF);
		host.wr(7'h42, 8'h00);
		rc(7'h42, 8'h09);
		rc(7'h47, 8'h0C);
		rc(7'h48, 8'h03);
		rc(7'h3F, 8'h03);
		rc(7'h40, 8'h05);
		rc(7'h41, 8'h0A);
		host.wr(7'h50, 8'hFF);
		rc(7'h50, 8'h00);
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_b = 1;
		t_cfg;
		t_srst(8'h80);
		t_srst(8'h01);
		t_cal;
		t_ro;
		wrap_up;
	end
	always @(posedge clk) begin
		if (++cyc == 2000) begin
			n_errors++;
			wrap_up;
		end
	end
endmodule // tb
`default_nettype wire
